// >>> rtl/mode_ctl_pkg.sv
`default_nettype none
package mode_ctl_pkg;
	localparam int CLK_HZ            = 25000000;
	// Timeouts in their own units (typical values)
	localparam int WDOG_TIMEOUT_MS   = 310;
	localparam int IN_IDLE_MS        = 250;
	localparam int WAKE_READY_US     = 50;
	localparam int WDOG_CYC          = WDOG_TIMEOUT_MS * (CLK_HZ / 1000);
	localparam int IN_IDLE_CYC       = IN_IDLE_MS * (CLK_HZ / 1000);
	localparam int WAKE_READY_CYC    = WAKE_READY_US * (CLK_HZ / 1000000);
	// SPI word layout
	localparam int SPI_BITS          = 16;
	localparam int WDOG_BIT_POS      = 15;
	localparam int WATCHDOG_DISABLE_POS        = 4;
	localparam int DUTY_MSB          = 7;
	localparam int CNT_W             = 24;
	// Defaults
	localparam logic [1:0] DIRECT_DELAY_SLEW = 2'h0;
	localparam logic [7:0] DUTY_RESET        = 8'h00;
	localparam logic [15:0] CFG_RESET        = 16'h0000;

	typedef enum logic [1:0] {
		MODE_SLEEP,
		MODE_NORMAL,
		MODE_FAILSAFE,
		MODE_FAULT
	} mode_e;
endpackage
`default_nettype wire

// >>> rtl/activity_timer.sv
`default_nettype none
module activity_timer #(
	parameter int unsigned LIMIT = 100
) (
	// Clock and reset
	input  wire logic clk_in,
	input  wire logic nrst_in,
	// Restart and status
	input  wire logic kick_in,
	output logic      expired_out
);
	import mode_ctl_pkg::*;

	typedef struct packed {
		logic [CNT_W-1:0] cnt;
		logic             exp;
	} tmr_s;

	tmr_s st_r;
	tmr_s st_nxt;

	always_comb begin
		st_nxt = st_r;
		if (kick_in) begin
			st_nxt.cnt = '0;
			st_nxt.exp = 1'b0;
		end else if (st_r.cnt >= CNT_W'(LIMIT)) begin
			st_nxt.exp = 1'b1;
		end else begin
			st_nxt.cnt = st_r.cnt + CNT_W'(1);
		end
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			st_r <= '{cnt: '0, exp: 1'b1};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign expired_out = st_r.exp;
endmodule // activity_timer
`default_nettype wire

// >>> rtl/duty_pwm.sv
`default_nettype none
module duty_pwm (
	// Clock and reset
	input  wire logic       clk_in,
	input  wire logic       nrst_in,
	// Duty setting and pulse
	input  wire logic [7:0] duty_in,
	output logic            pulse_out
);
	import mode_ctl_pkg::*;

	typedef struct packed {
		logic [7:0] phase;
		logic       pulse;
	} pwm_s;

	pwm_s st_r;
	pwm_s st_nxt;

	// Duty n gives (n+1)/256 on time; 8'hFF gives fully on
	always_comb begin
		st_nxt       = st_r;
		st_nxt.phase = st_r.phase + 8'h01;
		st_nxt.pulse = (st_r.phase <= duty_in[DUTY_MSB:0]);
	end

	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			st_r <= '{phase: 8'h00, pulse: 1'b0};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign pulse_out = st_r.pulse;
endmodule // duty_pwm
`default_nettype wire

// >>> rtl/mode_ctl.sv
`default_nettype none
// Function
// - normal_mode_flag is 1 when wake-up 1, fail-safe 0, fault 0.
// - Direct input mode follows input level with delay/slew setting 00.
// - Target = (in and not dir_dis) or (on and pulse and pwm_en) or (on, no pwm).
// - Duty pulse comes from the eight-bit duty field D7..D0.
// - Normal on reset pin rising with logic supply, or direct input rising.
// - Input-active flag drops after 250 ms without activity on that input.
// - Both inputs idle and reset pin 0 gives sleep, channels and SPI off.
// - Reset pin 0 or fail-safe: channels driven by direct inputs only.
// - Wake-up is reset pin or either input-active flag; picks the mode.
// - Fail-safe on enabled logic-supply failure or enabled watchdog timeout.
// - Fault on overcurrent, overtemp, short, undervoltage or enabled overvoltage.
// - Priority sleep, then fault, then fail-safe, else normal.
// - Watchdog runs only with logic supply, watchdog enabled, reset pin 1.
// - Watchdog disable is config bit D4; blocks fail-safe on timeout.
// - Sleep after power-up; configuration holds defaults during sleep.
// - Entering fail-safe from normal or sleep drives fail-safe output low, delatches, resets, blocks SPI.
// - Watchdog starts on reset pin rising; checks D15 of each word.
// - No watchdog bit change within 310 ms declares loss, enters fail-safe.
// - Leave fail-safe by D15=1 word, then second word within 310 ms.
// - Back to normal releases fail-safe output, resets registers, keeps latched.
// - SPI words are 16 bits, MSB first, data sampled on falling clock.
// - Wake-up resets registers; functions ready about 50 us later.
module mode_ctl
	import mode_ctl_pkg::*;
(
	// Clock and reset
	input  wire logic                clk_in,
	input  wire logic                nrst_in,
	// Pins from the host
	input  wire logic                reset_wake_pin_in,
	input  wire logic [1:0]          direct_in,
	input  wire logic                spi_cs_n_in,
	input  wire logic                spi_sclk_in,
	input  wire logic                spi_si_in,
	// Supply and protection status
	input  wire logic                logic_supply_ok_in,
	input  wire logic [1:0]          overcurrent_fault_in,
	input  wire logic [1:0]          overtemperature_fault_in,
	input  wire logic [1:0]          short_circuit_fault_in,
	input  wire logic                undervoltage_fault_in,
	input  wire logic                overvoltage_fault_in,
	input  wire logic [1:0]          latched_fault_in,
	// Configuration bits
	input  wire logic                logic_supply_fail_enable_in,
	input  wire logic                overvoltage_disable_in,
	input  wire logic [1:0]          direct_disable_in,
	input  wire logic [1:0]          on_bit_in,
	input  wire logic [1:0]          pwm_enable_in,
	input  wire logic [7:0]          duty0_in,
	input  wire logic [7:0]          duty1_in,
	// Mode and status
	output mode_ctl_pkg::mode_e      mode_out,
	output logic                     normal_mode_flag_out,
	output logic                     failsafe_out_n_out,
	output logic                     failsafe_out_n_oe_n_out,
	output logic                     functions_ready_out,
	output logic                     spi_enable_out,
	output logic                     regs_reset_out,
	output logic                     delatch_out,
	// SPI word and stored configuration
	output logic [15:0]              spi_word_out,
	output logic                     spi_word_valid_out,
	output logic                     watchdog_disable_out,
	output logic [15:0]              global_config_register_out,
	// Channel control
	output logic [1:0]               hson_out,
	output logic [1:0]               delay_slew_out
);
	import mode_ctl_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// State
	typedef struct packed {
		logic [1:0]          rst_sync;
		logic [1:0]          in_s0;
		logic [1:0]          in_s1;
		logic [1:0]          in_prev;
		logic                rst_prev;
		logic [2:0]          cs_sync;
		logic [2:0]          sck_sync;
		logic [1:0]          si_sync;
		logic [15:0]         shift;
		logic [4:0]          bitcnt;
		logic [15:0]         word;
		logic                word_vld;
		logic [15:0]         global_config_register;
		logic                wd_run;
		logic                wd_last;
		logic                wd_seen;
		logic [CNT_W-1:0]    wd_cnt;
		logic                wd_to;
		logic                supply_fail;
		logic                exit_arm;
		logic [CNT_W-1:0]    exit_cnt;
		logic [CNT_W-1:0]    ready_cnt;
		logic                ready;
		mode_e               mode;
		logic                fs_n;
		logic                regs_rst;
		logic                delatch;
		logic [1:0]          hson;
	} ctl_s;

	ctl_s st_r;
	ctl_s st_nxt;

	////////////////////////////////////////////////////////////////////////
	// Per-channel helpers
	logic [1:0] in_kick;
	logic [1:0] in_idle;
	logic [1:0] pulse;
	logic [7:0] duty [2];

	assign duty[0] = duty0_in;
	assign duty[1] = duty1_in;

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_ch
			assign in_kick[g] = st_r.in_s1[g] ^ st_r.in_prev[g];
			activity_timer #(.LIMIT(IN_IDLE_CYC)) u_idle (
				.clk_in     (clk_in),
				.nrst_in    (nrst_in),
				.kick_in    (in_kick[g] | st_r.in_s1[g]),
				.expired_out(in_idle[g])
			);
			duty_pwm u_pwm (
				.clk_in   (clk_in),
				.nrst_in  (nrst_in),
				.duty_in  (duty[g]),
				.pulse_out(pulse[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////
	// Next state
	logic       rst_pin;
	logic [1:0] in_pin;
	logic [1:0] in_active;
	logic       sck_fall;
	logic       cs_act;
	logic       wake;
	logic       fs_term;
	logic       fault_term;
	logic       word_done;
	logic       wd_bit;
	logic       wd_enable;
	mode_e      mode_new;
	logic [1:0] dir_ctl;
	logic [1:0] spi_ctl;

	always_comb begin
		st_nxt        = st_r;
		rst_pin       = st_r.rst_sync[1];
		in_pin        = st_r.in_s1;
		in_active     = ~in_idle;
		cs_act        = ~st_r.cs_sync[1];
		sck_fall      = st_r.sck_sync[2] & ~st_r.sck_sync[1];
		word_done     = 1'b0;
		wd_bit        = st_r.shift[WDOG_BIT_POS];
		dir_ctl       = 2'h0;
		spi_ctl       = 2'h0;

		// Pin synchronisers
		st_nxt.rst_sync = {st_r.rst_sync[0], reset_wake_pin_in};
		st_nxt.in_s0    = direct_in;
		st_nxt.in_s1    = st_r.in_s0;
		st_nxt.in_prev  = st_r.in_s1;
		st_nxt.rst_prev = rst_pin;
		st_nxt.cs_sync  = {st_r.cs_sync[1], st_r.cs_sync[0], spi_cs_n_in};
		st_nxt.sck_sync = {st_r.sck_sync[1], st_r.sck_sync[0], spi_sclk_in};
		st_nxt.si_sync  = {st_r.si_sync[0], spi_si_in};
		st_nxt.word_vld = 1'b0;
		st_nxt.delatch  = 1'b0;
		st_nxt.regs_rst = 1'b0;

		// SPI receiver, 16 bits MSB first on falling clock
		if (!cs_act || st_r.mode == MODE_SLEEP) begin
			st_nxt.bitcnt = 5'h00;
		end else if (sck_fall) begin
			st_nxt.shift  = {st_r.shift[14:0], st_r.si_sync[1]};
			st_nxt.bitcnt = st_r.bitcnt + 5'h01;
			if (st_r.bitcnt == 5'(SPI_BITS - 1)) begin
				word_done       = 1'b1;
				st_nxt.bitcnt   = 5'h00;
				wd_bit          = st_r.shift[14];
				st_nxt.word     = {st_r.shift[14:0], st_r.si_sync[1]};
				st_nxt.word_vld = 1'b1;
			end
		end

		// Watchdog
		wd_enable = logic_supply_ok_in & ~st_r.global_config_register[WATCHDOG_DISABLE_POS] & rst_pin;
		if (rst_pin && !st_r.rst_prev && logic_supply_ok_in) begin
			st_nxt.wd_run  = 1'b1;
			st_nxt.wd_cnt  = '0;
			st_nxt.wd_seen = 1'b0;
		end else if (!wd_enable || st_r.mode != MODE_NORMAL) begin
			st_nxt.wd_cnt = '0;
		end else if (st_r.wd_run) begin
			if (word_done && st_r.wd_seen && wd_bit != st_r.wd_last) begin
				st_nxt.wd_cnt = '0;
			end else if (st_r.wd_cnt >= CNT_W'(WDOG_CYC)) begin
				st_nxt.wd_to = 1'b1;
			end else begin
				st_nxt.wd_cnt = st_r.wd_cnt + CNT_W'(1);
			end
		end
		if (word_done) begin
			st_nxt.wd_last = wd_bit;
			st_nxt.wd_seen = 1'b1;
		end

		// Logic supply failure after it was present
		if (!logic_supply_ok_in && st_r.mode != MODE_SLEEP) begin
			st_nxt.supply_fail = 1'b1;
		end else if (logic_supply_ok_in && st_r.mode == MODE_SLEEP) begin
			st_nxt.supply_fail = 1'b0;
		end

		// Leaving fail-safe: D15=1 word, then a second word in time
		if (st_r.mode == MODE_FAILSAFE && word_done) begin
			if (!st_r.exit_arm && wd_bit) begin
				st_nxt.exit_arm = 1'b1;
				st_nxt.exit_cnt = '0;
			end else if (st_r.exit_arm) begin
				st_nxt.exit_arm = 1'b0;
				st_nxt.wd_to    = 1'b0;
				st_nxt.wd_cnt   = '0;
				// Supply back in range: the exit sequence also ends a supply failure
				if (logic_supply_ok_in) begin
					st_nxt.supply_fail = 1'b0;
				end
			end
		end else if (st_r.exit_arm) begin
			if (st_r.exit_cnt >= CNT_W'(WDOG_CYC)) begin
				st_nxt.exit_arm = 1'b0;
			end else begin
				st_nxt.exit_cnt = st_r.exit_cnt + CNT_W'(1);
			end
		end

		// Mode terms
		wake       = rst_pin | in_active[0] | in_active[1];
		fs_term    = (st_r.supply_fail & logic_supply_fail_enable_in)
			| (st_nxt.wd_to & ~st_r.global_config_register[WATCHDOG_DISABLE_POS]);
		fault_term = (|overcurrent_fault_in) | (|overtemperature_fault_in)
			| (|short_circuit_fault_in) | undervoltage_fault_in
			| (overvoltage_fault_in & ~overvoltage_disable_in);

		if (!wake) begin
			mode_new = MODE_SLEEP;
		end else if (fault_term) begin
			mode_new = MODE_FAULT;
		end else if (fs_term) begin
			mode_new = MODE_FAILSAFE;
		end else begin
			mode_new = MODE_NORMAL;
		end
		st_nxt.mode = mode_new;

		// Mode transition effects
		if (st_r.mode == MODE_SLEEP && mode_new != MODE_SLEEP) begin
			st_nxt.regs_rst  = 1'b1;
			st_nxt.ready_cnt = '0;
			st_nxt.ready     = 1'b0;
			st_nxt.global_config_register       = CFG_RESET;
			st_nxt.wd_to     = 1'b0;
		end else if (st_r.ready_cnt >= CNT_W'(WAKE_READY_CYC)) begin
			st_nxt.ready = 1'b1;
		end else begin
			st_nxt.ready_cnt = st_r.ready_cnt + CNT_W'(1);
		end
		if (fs_term && !st_r.mode[1] && mode_new != MODE_SLEEP) begin
			st_nxt.fs_n     = 1'b0;
			st_nxt.delatch  = 1'b1;
			st_nxt.regs_rst = 1'b1;
			st_nxt.global_config_register      = CFG_RESET;
		end
		if (st_r.mode == MODE_FAILSAFE && mode_new == MODE_NORMAL) begin
			st_nxt.fs_n     = 1'b1;
			st_nxt.regs_rst = 1'b1;
			st_nxt.global_config_register      = CFG_RESET;
		end
		if (mode_new == MODE_SLEEP) begin
			st_nxt.fs_n  = 1'b1;
			st_nxt.global_config_register   = CFG_RESET;
			st_nxt.wd_to = 1'b0;
		end

		// Configuration word store, blocked outside normal mode
		// No store in the cycle that leaves normal mode, so the reset stands
		if (st_r.word_vld && st_r.mode == MODE_NORMAL && !st_r.regs_rst
			&& mode_new == MODE_NORMAL) begin
			st_nxt.global_config_register = st_r.word;
		end

		// Channel targets
		dir_ctl = in_pin & ~direct_disable_in;
		spi_ctl = (on_bit_in & pulse & pwm_enable_in)
			| (on_bit_in & ~pwm_enable_in);
		case (mode_new)
			MODE_NORMAL: begin
				st_nxt.hson = rst_pin ? (dir_ctl | spi_ctl) : in_pin;
			end
			MODE_FAILSAFE: begin
				st_nxt.hson = in_pin;
			end
			default: begin
				st_nxt.hson = 2'h0;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////
	// Registers
	always_ff @(posedge clk_in) begin
		if (!nrst_in) begin
			st_r      <= '0;
			st_r.mode <= MODE_SLEEP;
			st_r.fs_n <= 1'b1;
			st_r.global_config_register  <= CFG_RESET;
			st_r.cs_sync  <= 3'h7;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs
	assign mode_out                   = st_r.mode;
	assign normal_mode_flag_out       = (st_r.mode == MODE_NORMAL);
	assign failsafe_out_n_out         = 1'b0;
	assign failsafe_out_n_oe_n_out    = st_r.fs_n;
	assign functions_ready_out        = st_r.ready & (st_r.mode != MODE_SLEEP);
	assign spi_enable_out             = (st_r.mode == MODE_NORMAL);
	assign regs_reset_out             = st_r.regs_rst;
	assign delatch_out                = st_r.delatch;
	assign spi_word_out               = st_r.word;
	assign spi_word_valid_out         = st_r.word_vld;
	assign watchdog_disable_out       = st_r.global_config_register[WATCHDOG_DISABLE_POS];
	assign global_config_register_out = st_r.global_config_register;
	assign hson_out                   = st_r.hson;
	assign delay_slew_out             = DIRECT_DELAY_SLEW;
endmodule // mode_ctl
`default_nettype wire

// >>> test/host_spi_model.sv
`default_nettype none
module host_spi_model (
	// Clock
	input  wire logic clk_in,
	// SPI pins toward the device
	output var logic  spi_cs_n_out,
	output var logic  spi_sclk_out,
	output var logic  spi_si_out
);
	timeunit 1ns;
	timeprecision 1ns;
	initial begin
		spi_cs_n_out = 1'b1;
		spi_sclk_out = 1'b0;
		spi_si_out   = 1'b0;
	end
	// Whole 16-bit word, MSB first, serial clock low around chip-select edges
	task automatic send_word(input logic [15:0] w);
		spi_cs_n_out <= 1'b0;
		repeat (4) @(posedge clk_in);
		for (int i = 15; i >= 0; i--) begin
			spi_sclk_out <= 1'b1;
			spi_si_out   <= w[i];
			repeat (4) @(posedge clk_in);
			spi_sclk_out <= 1'b0;
			repeat (4) @(posedge clk_in);
		end
		spi_cs_n_out <= 1'b1;
		spi_si_out   <= 1'b0;
		@(posedge clk_in);
	endtask
endmodule // host_spi_model
`default_nettype wire

// >>> test/mode_ctl_asserts.sv
`default_nettype none
module mode_ctl_asserts
	import mode_ctl_pkg::*;
(
	// Clock, reset and inputs
	input wire logic                clk_in,
	input wire logic                nrst_in,
	input wire logic                reset_wake_pin_in,
	input wire logic [1:0]          direct_in,
	input wire logic [1:0]          overcurrent_fault_in,
	input wire logic [1:0]          direct_disable_in,
	input wire logic [1:0]          on_bit_in,
	input wire logic [1:0]          pwm_enable_in,
	// Outputs
	input wire mode_ctl_pkg::mode_e mode_out,
	input wire logic                normal_mode_flag_out,
	input wire logic                failsafe_out_n_oe_n_out,
	input wire logic                spi_enable_out,
	input wire logic                delatch_out,
	input wire logic                watchdog_disable_out,
	input wire logic [15:0]         global_config_register_out,
	input wire logic [1:0]          hson_out,
	input wire logic [1:0]          delay_slew_out
);
	default clocking @(posedge clk_in); endclocking
	default disable iff (!nrst_in);
	////////////////////////////////////////////////////////////////
	property p_nm_flag; normal_mode_flag_out == (mode_out == MODE_NORMAL); endproperty
	a_nm_flag: assert property (p_nm_flag) else $error("nm flag");
	property p_sleep_off;
		mode_out == MODE_SLEEP && $past(mode_out) == MODE_SLEEP |-> !hson_out && !spi_enable_out;
	endproperty
	a_sleep_off: assert property (p_sleep_off) else $error("sleep outputs");
	property p_fault_off;
		mode_out == MODE_FAULT && $past(mode_out) == MODE_FAULT |-> hson_out == 2'h0;
	endproperty
	a_fault_off: assert property (p_fault_off) else $error("fault outputs");
	property p_fault_entry;
		(mode_out != MODE_SLEEP && reset_wake_pin_in && |overcurrent_fault_in)[*3]
			|-> mode_out == MODE_FAULT;
	endproperty
	a_fault_entry: assert property (p_fault_entry) else $error("fault entry");
	property p_fs_pin;
		mode_out == MODE_FAILSAFE && $past(mode_out) == MODE_NORMAL
			|-> ##[0:2] !failsafe_out_n_oe_n_out;
	endproperty
	a_fs_pin: assert property (p_fs_pin) else $error("fail-safe pin");
	property p_fs_delatch;
		mode_out == MODE_FAILSAFE && $past(mode_out) == MODE_NORMAL |-> ##[0:2] delatch_out;
	endproperty
	a_fs_delatch: assert property (p_fs_delatch) else $error("delatch");
	property p_fs_exit;
		mode_out == MODE_NORMAL && $past(mode_out) == MODE_FAILSAFE
			|-> ##[0:2] failsafe_out_n_oe_n_out;
	endproperty
	a_fs_exit: assert property (p_fs_exit) else $error("fail-safe release");
	property p_fs_direct;
		(mode_out == MODE_FAILSAFE && $stable(direct_in))[*5] |-> hson_out == direct_in;
	endproperty
	a_fs_direct: assert property (p_fs_direct) else $error("fail-safe drive");
	property p_hson_on;
		(mode_out == MODE_NORMAL && reset_wake_pin_in && $past(reset_wake_pin_in, 4)
			&& pwm_enable_in == 2'h0 && direct_disable_in == 2'h3
			&& $stable({on_bit_in, pwm_enable_in, direct_disable_in}))
			##1 mode_out == MODE_NORMAL |-> hson_out == $past(on_bit_in);
	endproperty
	a_hson_on: assert property (p_hson_on) else $error("on bit drive");
	property p_watchdog_disable; watchdog_disable_out == global_config_register_out[4]; endproperty
	a_watchdog_disable: assert property (p_watchdog_disable) else $error("watchdog disable");
	property p_slew; delay_slew_out == DIRECT_DELAY_SLEW; endproperty
	a_slew: assert property (p_slew) else $error("delay slew");
	c_normal: cover property (mode_out == MODE_NORMAL && $past(mode_out) == MODE_SLEEP);
	c_failsafe: cover property ($rose(mode_out == MODE_FAILSAFE));
	c_fault: cover property ($rose(mode_out == MODE_FAULT));
endmodule // mode_ctl_asserts
bind mode_ctl mode_ctl_asserts mode_ctl_asserts_i (.*);
`default_nettype wire

// >>> test/mode_ctl_tb_top.sv
`default_nettype none
module mode_ctl_tb_top;
	timeunit 1ns;
	timeprecision 1ns;
	import mode_ctl_pkg::*;
	logic        clk_in = 1'b0, nrst_in = 1'b0, reset_wake_pin_in = 1'b0;
	logic        logic_supply_ok_in = 1'b1, logic_supply_fail_enable_in = 1'b0;
	logic        overvoltage_disable_in = 1'b0, undervoltage_fault_in, overvoltage_fault_in;
	logic        spi_cs_n_in, spi_sclk_in, spi_si_in;
	logic [1:0]  direct_in = 2'h0, direct_disable_in = 2'h0, on_bit_in = 2'h0;
	logic [1:0]  pwm_enable_in = 2'h0, latched_fault_in = 2'h0;
	logic [1:0]  overcurrent_fault_in, overtemperature_fault_in, short_circuit_fault_in;
	logic [7:0]  duty0_in = 8'hFF, duty1_in = 8'hFF, fv = 8'h00, dv;
	mode_e       mode_out;
	logic        normal_mode_flag_out, failsafe_out_n_out, failsafe_out_n_oe_n_out;
	logic        functions_ready_out, spi_enable_out, regs_reset_out, delatch_out;
	logic        spi_word_valid_out, watchdog_disable_out;
	logic [1:0]  hson_out, delay_slew_out;
	logic [15:0] spi_word_out, global_config_register_out, got_word, w;
	int          error_cnt = 0, samples_checked = 0, seed = 82961, got_cnt = 0, c0, c1, rr_cnt = 0;
	assign {overcurrent_fault_in, overtemperature_fault_in, short_circuit_fault_in,
		undervoltage_fault_in, overvoltage_fault_in} = fv;
	always #20 clk_in = ~clk_in;
	mode_ctl mode_ctl_i (.*);
	host_spi_model host_spi_model_i (.clk_in(clk_in), .spi_cs_n_out(spi_cs_n_in),
		.spi_sclk_out(spi_sclk_in), .spi_si_out(spi_si_in));
	always @(posedge clk_in) begin
		if (spi_word_valid_out === 1'b1) begin
			got_word <= spi_word_out;
			got_cnt  <= got_cnt + 1;
		end
		if (regs_reset_out === 1'b1) begin
			rr_cnt <= rr_cnt + 1;
		end
	end
	////////////////////////////////////////////////////////////////
	task automatic tick(input int n);
		repeat (n) @(posedge clk_in);
	endtask
	task automatic check(input logic [15:0] seen, input logic [15:0] exp, input string msg);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t %s: saw %h want %h", $time, msg, seen, exp);
		end
	endtask
	task automatic wait_mode(input mode_e m);
		int n;
		n = 0;
		@(negedge clk_in);
		while (mode_out !== m && n < 300) begin
			@(negedge clk_in);
			n++;
		end
		check(mode_out, m, "mode");
		tick(1);
	endtask
	task automatic send(input logic [15:0] word);
		int n0;
		n0 = got_cnt;
		host_spi_model_i.send_word(word);
		tick(8);
		check(16'(got_cnt - n0), 16'h0001, "word count");
		check(got_word, word, "word");
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask
	// Target with full duty, v = {direct, disable, on, pwm enable}
	function automatic logic [1:0] exp_hson(input logic [7:0] v);
		return (v[7:6] & ~v[5:4]) | (v[3:2] & v[1:0]) | (v[3:2] & ~v[1:0]);
	endfunction
	////////////////////////////////////////////////////////////////
	initial begin
		tick(8);
		nrst_in <= 1'b1;
		tick(4);
		@(negedge clk_in);
		check(mode_out, MODE_SLEEP, "start mode");
		check(global_config_register_out, CFG_RESET, "start config");
		check({hson_out, failsafe_out_n_out, failsafe_out_n_oe_n_out}, 16'h0001, "start pins");
		$display("test power_up done");
		tick(1);
		reset_wake_pin_in <= 1'b1;
		wait_mode(MODE_NORMAL);
		check(normal_mode_flag_out, 1'b1, "nm flag");
		check(functions_ready_out, 1'b0, "early ready");
		check(spi_enable_out, 1'b1, "spi on");
		tick(WAKE_READY_CYC + 20);
		check(functions_ready_out, 1'b1, "ready");
		for (int i = 0; i < 6; i++) begin
			w = 16'($random(seed));
			w[15] = i[0];
			w[4] = i[1];
			send(w);
			check(global_config_register_out, w, "config");
			check(watchdog_disable_out, w[4], "wd disable");
		end
		$display("test spi done");
		for (int i = 0; i < 16; i++) begin
			dv = 8'($random(seed));
			{direct_in, direct_disable_in, on_bit_in, pwm_enable_in} <= dv;
			tick(8);
			check(hson_out, exp_hson(dv), "target");
		end
		{direct_in, on_bit_in, pwm_enable_in} <= 6'h0F;
		for (int j = 0; j < 3; j++) begin
			dv = (j == 0) ? 8'h00 : (j == 1) ? 8'($random(seed)) : 8'hFE;
			duty0_in <= dv;
			duty1_in <= 8'hFF - dv;
			tick(300);
			c0 = 0;
			c1 = 0;
			repeat (256) begin
				@(negedge clk_in);
				c0 += hson_out[0];
				c1 += hson_out[1];
			end
			check(16'(c0), 16'(dv) + 16'h1, "duty 0");
			check(16'(c1), 16'h100 - 16'(dv), "duty 1");
			tick(1);
		end
		$display("test channel done");
		{direct_in, direct_disable_in, on_bit_in, pwm_enable_in} <= 8'h7C;
		tick(8);
		reset_wake_pin_in <= 1'b0;
		tick(12);
		check(mode_out, MODE_NORMAL, "input wake");
		check(hson_out, 2'h1, "direct 1");
		direct_in <= 2'h3;
		tick(12);
		check(hson_out, 2'h3, "direct 3");
		reset_wake_pin_in <= 1'b1;
		overvoltage_disable_in <= 1'b1;
		fv <= 8'h01;
		tick(12);
		check(mode_out, MODE_NORMAL, "ov masked");
		overvoltage_disable_in <= 1'b0;
		for (int k = 0; k < 8; k++) begin
			fv <= 8'h01 << k;
			wait_mode(MODE_FAULT);
			tick(2);
			check(hson_out, 2'h0, "fault off");
			fv <= 8'h00;
			wait_mode(MODE_NORMAL);
		end
		$display("test fault done");
		logic_supply_ok_in <= 1'b0;
		tick(20);
		check(mode_out, MODE_NORMAL, "supply ignored");
		logic_supply_ok_in <= 1'b1;
		tick(4);
		logic_supply_fail_enable_in <= 1'b1;
		logic_supply_ok_in <= 1'b0;
		direct_in <= 2'h2;
		wait_mode(MODE_FAILSAFE);
		tick(8);
		check(failsafe_out_n_oe_n_out, 1'b0, "fs pin");
		check(global_config_register_out, CFG_RESET, "fs reset");
		check(hson_out, 2'h2, "fs direct");
		check(spi_enable_out, 1'b0, "spi blocked");
		send(16'h0010);
		check(global_config_register_out, CFG_RESET, "fs blocked");
		fv <= 8'h02;
		wait_mode(MODE_FAULT);
		fv <= 8'h00;
		wait_mode(MODE_FAILSAFE);
		logic_supply_ok_in <= 1'b1;
		send(16'h8000);
		send(16'h0010);
		wait_mode(MODE_NORMAL);
		check(failsafe_out_n_oe_n_out, 1'b1, "fs release");
		tick(2);
		check(16'(rr_cnt), 16'h0003, "reg resets");
		$display("test failsafe done");
		complete_run();
	end
	initial begin
		#2000000;
		error_cnt++;
		$display("[FAIL] %0t run too long", $time);
		complete_run();
	end
endmodule // mode_ctl_tb_top
`default_nettype wire
